// file: hdl/pgb_pkg.sv
// Constants and types for the paged external memory bus sequencer.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
package pgb_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 7;
  localparam int STR_W  = 4;

  localparam int CLOCK_MHZ = 100;

  // Control register layout
  localparam logic [7:0] ADDRESS_CONTROL_REG_RESET  = 8'h00;
  localparam int         ADDRESS_CONTROL_REG_EN_BIT = 7;
  localparam int         ADDRESS_CONTROL_REG_SEL_HI = 6;
  localparam int         ADDRESS_CONTROL_REG_SEL_LO = 5;

  localparam logic [1:0] SEL_ONE  = 2'h0;
  localparam logic [1:0] SEL_TWO  = 2'h1;
  localparam logic [1:0] SEL_FOUR = 2'h2;
  localparam logic [1:0] SEL_PM2  = 2'h3;

  // Phase lengths in system clocks; a miss is a latch half then a hit half
  localparam logic [CNT_W-1:0] HIT_ONE   = 7'h01;
  localparam logic [CNT_W-1:0] HIT_TWO   = 7'h02;
  localparam logic [CNT_W-1:0] HIT_FOUR  = 7'h04;
  localparam logic [CNT_W-1:0] PM2_HALF  = 7'h02;
  localparam logic [CNT_W-1:0] NP_ALE    = 7'h01;
  localparam logic [CNT_W-1:0] NP_STB    = 7'h03;
  localparam logic [CNT_W-1:0] STRETCH_C = 7'h04;
  localparam logic [CNT_W-1:0] CNT_ONE   = 7'h01;

  typedef enum logic [1:0] {PGB_CODE, PGB_READ, PGB_WRITE} pgb_kind_t;

  typedef struct packed {
    pgb_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [STR_W-1:0]  stretch;
  } pgb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic              oe;
  } pgb_pin_t;
endpackage

// file: hdl/pgb_paged_bus.sv
// Paged external memory bus sequencer: one access at a time from the core.
// Assumes pins are joined outside from dout/oe; pin inputs are asynchronous.
`timescale 1ns/1ns
module pgb_paged_bus
  import pgb_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Control register write port
  input  wire logic              address_control_reg_wr_en,
  input  wire logic [7:0]        address_control_reg_wdata,
  input  wire logic              address_control_reg_timed_ok,
  // Control and status
  output logic                   page_mode_enable,
  output logic [1:0]             page_select,
  output logic                   page_miss,
  // Core request and answer
  input  wire logic              req_valid,
  input  wire pgb_req_t          req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  // External bus pins
  input  wire logic [DATA_W-1:0] low_port_bus_in,
  output pgb_pin_t               low_port_bus,
  input  wire logic [DATA_W-1:0] high_port_bus_in,
  output pgb_pin_t               high_port_bus,
  output logic                   addr_latch_strobe,
  output logic                   program_store_strobe_n,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n
);

  typedef enum logic [1:0] {PGB_IDLE, PGB_ALE, PGB_STB} pgb_state_t;

  logic [7:0]        address_control_reg_q;
  pgb_state_t        st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [CNT_W-1:0]  stbl_q, stbl_d;
  pgb_req_t          cur_q, cur_d;
  logic [7:0]        page_q;
  logic              page_valid_q;
  logic              after_move_q;
  logic              ready_q, miss_q;
  logic [1:0]        cap_q, cap_hi_q;
  logic              rsp_valid_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic [DATA_W-1:0] lp_s1_q, lp_s2_q, hp_s1_q, hp_s2_q;
  pgb_pin_t          lp_q, lp_d, hp_q, hp_d;
  logic              ale_q, program_store_strobe_n_n_q, rd_n_q, wr_n_q;

  // Configuration decode
  wire       pgen       = address_control_reg_q[ADDRESS_CONTROL_REG_EN_BIT];
  wire [1:0] sel        = address_control_reg_q[ADDRESS_CONTROL_REG_SEL_HI:ADDRESS_CONTROL_REG_SEL_LO];
  wire       pm2        = pgen && (sel == SEL_PM2);
  wire       address_control_reg_take  = address_control_reg_wr_en && address_control_reg_timed_ok;
  wire       new_en     = address_control_reg_wdata[ADDRESS_CONTROL_REG_EN_BIT];
  wire [1:0] new_sel    = address_control_reg_wdata[ADDRESS_CONTROL_REG_SEL_HI:ADDRESS_CONTROL_REG_SEL_LO];
  wire       invalidate = address_control_reg_take && ((new_en && !pgen) || (new_sel != sel));

  // Request classification
  wire is_code   = (req.kind == PGB_CODE);
  wire is_data   = !is_code;
  wire sel_one   = pgen && (sel == SEL_ONE);
  wire hi_match  = page_valid_q && (req.addr[15:8] == page_q);
  wire force_mis = !pgen || (pm2 && is_data)
                   || (sel_one && (is_data || after_move_q));
  wire miss      = force_mis || !hi_match;

  wire [CNT_W-1:0] hit_len = (sel == SEL_ONE)  ? HIT_ONE :
                             (sel == SEL_TWO)  ? HIT_TWO :
                             (sel == SEL_FOUR) ? HIT_FOUR : PM2_HALF;
  wire [CNT_W-1:0] ale_len = !pgen ? NP_ALE : hit_len;
  wire [CNT_W-1:0] base_sl = !pgen ? NP_STB : hit_len;
  wire [CNT_W-1:0] str_add = is_data ? CNT_W'(req.stretch * STRETCH_C) : '0;
  wire [CNT_W-1:0] stb_len = base_sl + str_add;

  wire start   = req_valid && ready_q;
  wire stb_end = (st_q == PGB_STB) && (cnt_q == '0);

  // Sequencer next state; a new access may start in the last strobe clock
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    stbl_d = stbl_q;
    cur_d  = cur_q;
    if (st_q == PGB_IDLE || stb_end) begin
      st_d = PGB_IDLE;
      if (start) begin
        cur_d  = req;
        stbl_d = stb_len;
        st_d   = miss ? PGB_ALE : PGB_STB;
        cnt_d  = (miss ? ale_len : stb_len) - CNT_ONE;
      end
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_ONE;
    end else begin
      st_d  = PGB_STB; // Second half runs as a hit
      cnt_d = stbl_q - CNT_ONE;
    end
  end

  // Pin values for the phase being entered, so pins come from flops
  wire in_ale  = (st_d == PGB_ALE);
  wire in_stb  = (st_d == PGB_STB);
  wire busy_d  = (st_d != PGB_IDLE);
  wire wr_d    = (cur_d.kind == PGB_WRITE);
  wire ready_d = (st_d == PGB_IDLE) || (in_stb && cnt_d == '0);

  always_comb begin
    hp_d = '{dout: cur_d.addr[15:8], oe: busy_d};
    lp_d = '{dout: cur_d.addr[7:0], oe: 1'b0};
    if (!pgen) begin
      lp_d.oe = in_ale || (in_stb && wr_d);
      if (in_stb) begin
        lp_d.dout = cur_d.wdata;
      end
    end else if (pm2) begin
      lp_d.oe = busy_d;
      if (in_stb) begin
        hp_d = '{dout: cur_d.wdata, oe: wr_d};
      end
    end else if (in_stb) begin
      hp_d.dout = cur_d.addr[7:0];
      lp_d      = '{dout: cur_d.wdata, oe: wr_d};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      address_control_reg_q <= ADDRESS_CONTROL_REG_RESET;
    end else if (address_control_reg_take) begin
      address_control_reg_q <= address_control_reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q   <= PGB_IDLE;
      cnt_q  <= '0;
      stbl_q <= '0;
      cur_q  <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      stbl_q <= stbl_d;
      cur_q  <= cur_d;
    end
  end

  // Page register; a config change outranks a same-cycle capture
  always_ff @(posedge clock) begin
    if (reset) begin
      page_q       <= '0;
      page_valid_q <= 1'b0;
    end else if (invalidate) begin
      page_valid_q <= 1'b0;
    end else if (start && miss) begin
      page_q       <= req.addr[15:8];
      page_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      after_move_q <= 1'b0;
    end else if (start) begin
      after_move_q <= is_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ready_q  <= 1'b0;
      miss_q   <= 1'b0;
      hp_q     <= '0;
      lp_q     <= '0;
      ale_q    <= 1'b0;
      program_store_strobe_n_n_q <= 1'b1;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
    end else begin
      ready_q  <= ready_d;
      miss_q   <= start && miss;
      hp_q     <= hp_d;
      lp_q     <= lp_d;
      ale_q    <= in_ale;
      program_store_strobe_n_n_q <= !(in_stb && cur_d.kind == PGB_CODE);
      rd_n_q   <= !(in_stb && cur_d.kind == PGB_READ);
      wr_n_q   <= !(in_stb && wr_d);
    end
  end

  // Two-flop synchronisers on the port inputs
  always_ff @(posedge clock) begin
    if (reset) begin
      lp_s1_q <= '0;
      lp_s2_q <= '0;
      hp_s1_q <= '0;
      hp_s2_q <= '0;
    end else begin
      lp_s1_q <= low_port_bus_in;
      lp_s2_q <= lp_s1_q;
      hp_s1_q <= high_port_bus_in;
      hp_s2_q <= hp_s1_q;
    end
  end

  // Capture delayed to match synchroniser depth: sees pin at strobe release
  always_ff @(posedge clock) begin
    if (reset) begin
      cap_q       <= '0;
      cap_hi_q    <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
    end else begin
      cap_q       <= {cap_q[0], stb_end && cur_q.kind != PGB_WRITE};
      cap_hi_q    <= {cap_hi_q[0], pm2};
      rsp_valid_q <= cap_q[1];
      if (cap_q[1]) begin
        rsp_data_q <= cap_hi_q[1] ? hp_s2_q : lp_s2_q;
      end
    end
  end

  assign page_mode_enable       = address_control_reg_q[ADDRESS_CONTROL_REG_EN_BIT];
  assign page_select            = address_control_reg_q[ADDRESS_CONTROL_REG_SEL_HI:ADDRESS_CONTROL_REG_SEL_LO];
  assign page_miss              = miss_q;
  assign req_ready              = ready_q;
  assign rsp_valid              = rsp_valid_q;
  assign rsp_data               = rsp_data_q;
  assign low_port_bus           = lp_q;
  assign high_port_bus          = hp_q;
  assign addr_latch_strobe      = ale_q;
  assign program_store_strobe_n = program_store_strobe_n_n_q;
  assign read_strobe_n          = rd_n_q;
  assign write_strobe_n         = wr_n_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence latch_half_four;
    ale_q && program_store_strobe_n_n_q && rd_n_q && wr_n_q && !lp_q.oe [*4];
  endsequence

  sequence code_strobe_four;
    (!ale_q && !program_store_strobe_n_n_q && !ready_q) [*3] ##1 (!program_store_strobe_n_n_q && ready_q);
  endsequence

  hit_no_latch_a: assert property (
    start && !miss && pgen |=> !ale_q && (pm2 || cur_q.addr[7:0] == hp_q.dout))
    else $error("Latch strobe or wrong byte on a page hit");

  miss_head_a: assert property (
    start && miss && pgen && !pm2 |=> ale_q && program_store_strobe_n_n_q && rd_n_q && wr_n_q && !lp_q.oe)
    else $error("Miss first half not idle with latch strobe");

  move_forces_miss_a: assert property (
    start && sel_one && is_data |-> miss)
    else $error("Data move under one-clock mode did not miss");

  fetch_after_move_a: assert property (
    start && sel_one && is_code && after_move_q |-> miss)
    else $error("Fetch after data move did not miss");

  timed_write_a: assert property (
    address_control_reg_wr_en && !address_control_reg_timed_ok |=> $stable(address_control_reg_q))
    else $error("Control register changed without timed access");

  fetch_floats_low_a: assert property (
    st_q == PGB_STB && cur_q.kind == PGB_CODE && pgen && !pm2 |-> !lp_q.oe && !program_store_strobe_n_n_q)
    else $error("Low port driven during page mode 1 fetch");

  two_clock_hit_a: assert property (
    start && !miss && is_code && pgen && sel == SEL_TWO |=> !ready_q ##1 ready_q)
    else $error("Two-clock hit has wrong length");

  four_miss_a: assert property (
    start && miss && is_code && pgen && sel == SEL_FOUR |=> latch_half_four ##1 code_strobe_four)
    else $error("Four-clock mode miss is not eight clocks");

  pm2_data_a: assert property (
    start && pm2 && is_data && req.stretch == '0 |=> ale_q [*2] ##1 !ready_q ##1 ready_q)
    else $error("Page mode 2 data access is not four clocks");

  one_clock_run_a: assert property (
    start && !miss && is_code && sel_one ##1 start && !miss && is_code |=> !program_store_strobe_n_n_q)
    else $error("Program store strobe dropped between hit fetches");

endmodule

// file: tb/pgb_ext_mem.sv
// External memory with clocked address latch (upper byte, and lower byte in non-page mode) for the paged bus.
// Assumes the bench tells it the bus mode; resolves both port pins.
`timescale 1ns/1ns
module pgb_ext_mem
  import pgb_pkg::*;
(
  // Clock and bus mode
  input  wire logic       clock,
  input  wire logic       mode_en,
  input  wire logic [1:0] mode_sel,
  // Device pins
  input  wire pgb_pin_t   low_port_bus,
  input  wire pgb_pin_t   high_port_bus,
  input  wire logic       ale,
  input  wire logic       program_store_strobe_n_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // Resolved pin levels
  output logic [7:0]      low_in,
  output logic [7:0]      high_in
);
  logic [7:0]  hi_q, lo_q, low_last, high_last, last_wd;
  logic [15:0] last_wa;
  initial begin
    low_last = 8'h00;
    high_last = 8'h00;
    last_wa = 16'h0000;
    last_wd = 8'h00;
  end
  wire        mode2 = mode_en && mode_sel == SEL_PM2;
  wire [15:0] addr  = mode2 ? {hi_q, low_port_bus.dout} :
                      mode_en ? {hi_q, high_port_bus.dout} : {hi_q, lo_q};
  wire [7:0]  rdata = (addr == last_wa) ? last_wd : addr[7:0] ^ addr[15:8] ^ 8'h5a;
  wire        rd_act = !program_store_strobe_n_n || !rd_n;
  // Released lines toggle so a stale value never passes for data
  assign low_in  = low_port_bus.oe ? low_port_bus.dout :
                   (rd_act && !mode2) ? rdata : ~low_last;
  assign high_in = high_port_bus.oe ? high_port_bus.dout :
                   (rd_act && mode2) ? rdata : ~high_last;
  always_ff @(posedge clock) begin
    low_last <= low_in;
    high_last <= high_in;
    if (ale) begin
      hi_q <= high_port_bus.dout;
      if (low_port_bus.oe) lo_q <= low_port_bus.dout;
    end
    if (!wr_n) begin
      last_wa <= addr;
      last_wd <= mode2 ? high_port_bus.dout : low_port_bus.dout;
    end
  end
endmodule

// file: tb/tb_paged_external_memory_bus.sv
// Self-checking bench for the paged bus sequencer, one access at a time.
// Assumes the external memory model answers reads from its own pattern, or from its last write at that address.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_paged_external_memory_bus;
  import pgb_pkg::*;
  logic        clock = 0, reset = 1, address_control_reg_wr_en = 0, address_control_reg_timed_ok = 0, req_valid = 0;
  logic [7:0]  address_control_reg_wdata = 8'h00, rsp_data, low_in, high_in, wr_d = 8'h00;
  logic [15:0] wr_a = 16'h0000;
  logic [1:0]  page_select;
  logic        page_mode_enable, page_miss, req_ready, rsp_valid;
  logic        ale, program_store_strobe_n_n, rd_n, wr_n;
  pgb_req_t    req = '0;
  pgb_pin_t    low_port_bus, high_port_bus;
  int          num_errors = 0, n_checks = 0;
  pgb_paged_bus dut (.clock(clock), .reset(reset), .address_control_reg_wr_en(address_control_reg_wr_en),
    .address_control_reg_wdata(address_control_reg_wdata), .address_control_reg_timed_ok(address_control_reg_timed_ok),
    .page_mode_enable(page_mode_enable), .page_select(page_select),
    .page_miss(page_miss), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .low_port_bus_in(low_in),
    .low_port_bus(low_port_bus), .high_port_bus_in(high_in),
    .high_port_bus(high_port_bus), .addr_latch_strobe(ale),
    .program_store_strobe_n(program_store_strobe_n_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n));
  pgb_ext_mem mem (.clock(clock), .mode_en(page_mode_enable), .mode_sel(page_select),
    .low_port_bus(low_port_bus), .high_port_bus(high_port_bus), .ale(ale),
    .program_store_strobe_n_n(program_store_strobe_n_n), .rd_n(rd_n), .wr_n(wr_n), .low_in(low_in), .high_in(high_in));
  initial begin
    forever #5 clock = ~clock;
  end
  task conclude;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task address_control_reg(input logic [7:0] d, input logic ok);
    @(posedge clock);
    address_control_reg_wr_en <= 1;
    address_control_reg_wdata <= d;
    address_control_reg_timed_ok <= ok;
    @(posedge clock);
    address_control_reg_wr_en <= 0;
    address_control_reg_timed_ok <= 0;
    @(posedge clock);
  endtask
  // Window of 30 clocks covers the longest access plus the answer delay
  task access(input pgb_kind_t k, input logic [15:0] a, input logic [3:0] s,
              input int eb, input int ea, input logic em);
    int busy, al, lo, nr, i;
    logic miss;
    logic [7:0] ed, got;
    busy = 0; al = 0; lo = 0; nr = 0; i = 0; miss = 0; got = 8'h00;
    ed = (a == wr_a) ? wr_d : a[7:0] ^ a[15:8] ^ 8'h5a;
    @(posedge clock);
    req_valid <= 1;
    req <= '{kind: k, addr: a, wdata: ~a[7:0], stretch: s};
    // Ready is looked at mid-cycle, so the take edge is known before it comes
    @(negedge clock);
    while (req_ready !== 1 && i < 50) begin
      @(negedge clock);
      i++;
    end
    @(posedge clock);
    req_valid <= 0;
    repeat (30) begin
      @(negedge clock);
      if (ale === 1) al++;
      if (ale === 1 || program_store_strobe_n_n === 0 || rd_n === 0 || wr_n === 0) busy++;
      if (low_port_bus.oe === 1 && busy > 0) lo++;
      if (page_miss === 1) miss = 1;
      if (rsp_valid === 1) begin
        nr++;
        got = rsp_data;
      end
    end
    `CHK("busy clocks", eb, busy)
    `CHK("latch clocks", ea, al)
    `CHK("miss flag", em, miss)
    if (k == PGB_WRITE) begin
      wr_a = a;
      wr_d = ~a[7:0];
      `CHK("answers", 0, nr)
    end else begin
      `CHK("answers", 1, nr)
      `CHK("read data", ed, got)
    end
    if (page_mode_enable === 1 && page_select !== SEL_PM2 && k != PGB_WRITE)
      `CHK("low port driven", 0, lo)
  endtask
  task t_nonpage;
    `CHK("enable", 1'b0, page_mode_enable)
    access(PGB_CODE, 16'h5610, 0, 4, 1, 1);
    access(PGB_READ, 16'h5620, 1, 8, 1, 1);
    address_control_reg(8'h80, 0);
    `CHK("refused write", 1'b0, page_mode_enable)
  endtask
  task t_mode1(input logic [1:0] sel, input int h);
    logic one;
    one = (sel == SEL_ONE);
    address_control_reg({1'b1, sel, 5'h00}, 1);
    `CHK("select", sel, page_select)
    access(PGB_CODE, 16'h5634, 0, 2 * h, h, 1);
    access(PGB_CODE, 16'h5656, 0, h, 0, 0);
    access(PGB_READ, 16'h5678, 0, one ? 2 * h : h, one ? h : 0, one);
    access(PGB_CODE, 16'h5680, 0, one ? 2 * h : h, one ? h : 0, one);
    access(PGB_WRITE, 16'h3400, 1, 2 * h + 4, h, 1);
    access(PGB_READ, 16'h3400, 0, one ? 2 * h : h, one ? h : 0, one);
    access(PGB_CODE, 16'h5690, 0, 2 * h, h, 1);
  endtask
  task t_mode2;
    address_control_reg(8'he0, 1);
    access(PGB_CODE, 16'h5610, 0, 4, 2, 1);
    access(PGB_CODE, 16'h5620, 0, 2, 0, 0);
    access(PGB_READ, 16'h5630, 0, 4, 2, 1);
    access(PGB_WRITE, 16'h5640, 1, 8, 2, 1);
    access(PGB_READ, 16'h5640, 0, 4, 2, 1);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    t_nonpage();
    t_mode1(SEL_ONE, 1);
    t_mode1(SEL_TWO, 2);
    t_mode1(SEL_FOUR, 4);
    t_mode2();
    conclude();
  end
endmodule
